// ===== nfh_ctrl.sv
// NAND flash host controller: sequences commands, up to five address cycles, data
// and busy waits on the flash pins. Assumes a byte-wide flash with an
// open-drain ready/busy line pulled up externally; pins are asynchronous.
//
// Overview of operation
// RULE1 - Command byte latched with command qualifier high
// RULE2 - Address byte latched with address qualifier high
// RULE3 - One shared byte port, time-multiplexed
// RULE4 - Chip select high while ready gives standby
// RULE5 - Chip select ignored during busy operations
// RULE6 - Falling read strobe gives next byte
// RULE7 - Write protect low blocks program, erase
// RULE8 - Write protect low resets flash regulator
// RULE9 - Long read strobe high releases outputs
// RULE10 - Short high keeps outputs, later release
// RULE11 - ECC query reads all four sector reports
// RULE12 - ECC query only after ready, before data
// RULE13 - At most four partial programs per page; code counts only the last programmed page
// RULE14 - Reset completes within bounded time
// RULE15 - Page program done within 700 us
// RULE16 - Busy after 11h at most 1 us
// RULE17 - Array read done within 120/200 us
// RULE18 - Host never drives while flash outputs
// RULE19 - Ready/busy low during operations
// RULE20 - Five address cycles, column then row
// RULE21 - Fixed command codes; busy accepts status, reset
// RULE22 - Power-on read preloads first read command
`timescale 1ns/1ns
module nfh_ctrl
   import nfh_pkg::*;
#(
   parameter int PROG_TIMEOUT  = PROG_TIME_CYC,
   parameter int ERASE_TIMEOUT = ERASE_TIME_CYC
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // User request
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire nfh_op_type  req_op,
   input  wire logic [11:0] req_col,
   input  wire logic [16:0] req_row,
   input  wire logic [11:0] req_len,
   input  wire logic        req_wp_n,
   // User write data
   input  wire logic [7:0]  wr_data,
   output logic             wr_take,
   // User read data and completion
   output logic [7:0]       rd_data_q,
   output logic             rd_valid_q,
   output logic             op_done_q,
   output logic             op_timeout_q,
   output logic             op_refused_q,
   // Flash pins
   output logic             chip_sel_n_q,
   output logic             cmd_latch,
   output logic             addr_latch,
   output logic             write_strobe_n,
   output logic             read_strobe_n,
   output logic             write_protect_n_q,
   input  wire logic        ready_busy_out,
   input  wire logic [7:0]  shared_byte_port_in,
   output logic [7:0]       shared_byte_port_out,
   output logic             shared_byte_port_oe
);
   typedef enum logic [7:0] {
      M_IDLE  = 8'b00000001,
      M_CMD1  = 8'b00000010,
      M_ADDR  = 8'b00000100,
      M_DIN   = 8'b00001000,
      M_CMD2  = 8'b00010000,
      M_BUSY  = 8'b00100000,
      M_DOUT  = 8'b01000000,
      M_END   = 8'b10000000
   } nfh_mst_type;
   nfh_mst_type  mst_q;
   nfh_op_type   op_q;
   logic [11:0]  col_q;
   logic [16:0]  row_q;
   logic [11:0]  left_q;
   logic [2:0]   acnt_q;
   logic [22:0]  wdog_q;
   logic [1:0]   rb_sync_q;
   logic [7:0]   pin_s1_q;
   logic [7:0]   pin_s2_q;
   logic         cy_start;
   nfh_cyc_type  cy_kind;
   logic [7:0]   cy_wdata;
   logic         cy_done;
   logic [7:0]   cy_rdata;
   logic         rb;
   logic [16:0]  pp_row_q;
   logic [2:0]   pp_cnt_q;

   // Pin synchronisers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rb_sync_q <= 2'b00;
         pin_s1_q  <= 8'h00;
         pin_s2_q  <= 8'h00;
      end else begin
         rb_sync_q <= {rb_sync_q[0], ready_busy_out};
         pin_s1_q  <= shared_byte_port_in;
         pin_s2_q  <= pin_s1_q;
      end
   end
   assign rb = rb_sync_q[1];

   // Five address bytes, unused bits driven low
   function automatic logic [7:0] addr_byte(input logic [2:0] idx,
                                            input logic [11:0] c,
                                            input logic [16:0] r);
      case (idx)
         3'h0:    addr_byte = c[7:0];
         3'h1:    addr_byte = {4'h0, c[11:8]};
         3'h2:    addr_byte = r[7:0];
         3'h3:    addr_byte = r[15:8];
         default: addr_byte = {7'h00, r[16]};
      endcase
   endfunction

   function automatic logic [7:0] first_cmd(input nfh_op_type o);
      case (o)
         OP_PROG:   first_cmd = CMD_PROG_1;
         OP_ERASE:  first_cmd = CMD_ERASE_1;
         OP_ID:     first_cmd = CMD_ID;
         OP_STATUS: first_cmd = CMD_STATUS;
         OP_ECC:    first_cmd = CMD_ECC_STAT;
         OP_RESET:  first_cmd = CMD_RESET;
         default:   first_cmd = CMD_READ_1;
      endcase
   endfunction

   // Erase starts at the row bytes only
   logic [2:0] addr_first;
   assign addr_first = (op_q == OP_ERASE) ? 3'h2 : 3'h0;

   always_comb begin
      cy_start = 1'b0;
      cy_kind  = CYC_CMD;
      cy_wdata = 8'h00;
      case (mst_q)
         M_CMD1: begin
            cy_start = 1'b1;
            cy_wdata = first_cmd(op_q); // RULE21
         end
         M_ADDR: begin
            cy_start = 1'b1;
            cy_kind  = CYC_ADDR;
            cy_wdata = addr_byte(acnt_q, col_q, row_q); // RULE20
         end
         M_DIN: begin
            cy_start = 1'b1;
            cy_kind  = CYC_DIN;
            cy_wdata = wr_data;
         end
         M_CMD2: begin
            cy_start = 1'b1;
            cy_wdata = (op_q == OP_PROG)  ? CMD_PROG_2 :
                       (op_q == OP_ERASE) ? CMD_ERASE_2 : CMD_READ_2; // RULE21
         end
         M_DOUT: begin
            cy_start = 1'b1;
            cy_kind  = CYC_DOUT;
         end
         default: cy_start = 1'b0;
      endcase
   end

   assign req_ready = (mst_q == M_IDLE);
   assign wr_take   = (mst_q == M_DIN) && cy_done;

   // Sequencer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mst_q        <= M_IDLE;
         op_q         <= OP_READ;
         col_q        <= 12'h000;
         row_q        <= 17'h00000;
         left_q       <= 12'h000;
         acnt_q       <= 3'h0;
         wdog_q       <= 23'h000000;
         op_done_q    <= 1'b0;
         op_timeout_q <= 1'b0;
         op_refused_q <= 1'b0;
      end else begin
         op_done_q    <= 1'b0;
         op_refused_q <= 1'b0;
         case (mst_q)
            M_IDLE: begin
               if (req_valid) begin
                  op_q   <= req_op;
                  col_q  <= req_col;
                  row_q  <= req_row;
                  left_q <= (req_op == OP_ECC) ? 12'(ECC_SECTORS) : req_len; // RULE11
                  // Flash refuses these while protected; skip pin traffic
                  if ((req_op == OP_PROG || req_op == OP_ERASE) && !req_wp_n) begin
                     op_refused_q <= 1'b1; // RULE7
                  end else if (req_op == OP_PROG && req_row == pp_row_q
                               && pp_cnt_q >= 3'(MAX_PARTIAL_PROG)) begin
                     op_refused_q <= 1'b1; // RULE13
                  end else if (rb || req_op == OP_STATUS || req_op == OP_RESET) begin
                     op_timeout_q <= 1'b0;
                     mst_q        <= M_CMD1; // RULE21
                  end
               end
            end
            M_CMD1: if (cy_done) begin
               acnt_q <= addr_first;
               case (op_q)
                  OP_READ, OP_PROG, OP_ERASE: mst_q <= M_ADDR;
                  OP_ID: begin
                     acnt_q <= 3'h4;
                     mst_q  <= M_ADDR;
                  end
                  OP_RESET: mst_q <= M_BUSY; // RULE14
                  default:  mst_q <= M_DOUT; // RULE12
               endcase
               wdog_q <= 23'h000000;
            end
            M_ADDR: if (cy_done) begin
               acnt_q <= acnt_q + 3'h1;
               if (acnt_q == 3'(ADDR_CYCLES - 1)) begin
                  mst_q <= (op_q == OP_PROG) ? M_DIN :
                           (op_q == OP_ID)   ? M_DOUT : M_CMD2;
               end
            end
            M_DIN: if (cy_done) begin
               left_q <= left_q - 12'h001;
               if (left_q <= 12'h001) mst_q <= M_CMD2;
            end
            M_CMD2: if (cy_done) begin
               wdog_q <= 23'h000000;
               mst_q  <= M_BUSY;
            end
            M_BUSY: begin
               // Wait past the ready-to-busy delay, then for ready
               wdog_q <= wdog_q + 23'h000001;
               if (wdog_q > 23'(WE_TO_BUSY_CYC + 2) && rb) begin
                  mst_q <= (op_q == OP_READ) ? M_DOUT : M_END; // RULE19 RULE17
               end else if (wdog_q >= 23'(ERASE_TIMEOUT)) begin
                  op_timeout_q <= 1'b1; // RULE15 RULE14
                  mst_q        <= M_END;
               end else if (op_q == OP_PROG && wdog_q >= 23'(PROG_TIMEOUT)) begin
                  op_timeout_q <= 1'b1; // RULE15
                  mst_q        <= M_END;
               end
            end
            M_DOUT: if (cy_done) begin
               left_q <= left_q - 12'h001;
               if (left_q <= 12'h001) mst_q <= M_END; // RULE11
            end
            M_END: begin
               op_done_q <= 1'b1;
               mst_q     <= M_IDLE;
            end
            default: mst_q <= M_IDLE;
         endcase
      end
   end

   // Erase does not clear the count, so reprogramming needs another page first
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pp_row_q <= 17'h00000;
         pp_cnt_q <= 3'h0;
      end else if (mst_q == M_CMD1 && cy_done && op_q == OP_PROG) begin
         pp_row_q <= row_q;
         pp_cnt_q <= (row_q == pp_row_q) ? pp_cnt_q + 3'h1 : 3'h1; // RULE13
      end
   end

   // Read data to user
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_data_q  <= 8'h00;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= (mst_q == M_DOUT) && cy_done;
         if ((mst_q == M_DOUT) && cy_done) rd_data_q <= cy_rdata;
      end
   end

   // Chip select: dropped when idle and ready so the flash can stand by
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         chip_sel_n_q      <= 1'b1;
         write_protect_n_q <= 1'b0;
      end else begin
         chip_sel_n_q      <= (mst_q == M_IDLE) && rb && !req_valid; // RULE4 RULE5
         // Follows req_wp_n; held low, it keeps the regulator in reset
         write_protect_n_q <= req_wp_n; // RULE8
      end
   end

   nfh_cycle u_cycle (
      .clk              (clk),
      .resetn           (resetn),
      .start            (cy_start && !cy_done),
      .kind             (cy_kind),
      .wdata            (cy_wdata),
      .done             (cy_done),
      .rdata_q          (cy_rdata),
      .port_in          (pin_s2_q),
      .cmd_latch_q      (cmd_latch),
      .addr_latch_q     (addr_latch),
      .write_strobe_n_q (write_strobe_n),
      .read_strobe_n_q  (read_strobe_n),
      .port_out_q       (shared_byte_port_out),
      .port_oe_q        (shared_byte_port_oe)
   );

   chk_prot_refuse: assert property (@(posedge clk) disable iff (!resetn)
      (mst_q == M_IDLE && req_valid && !req_wp_n && (req_op == OP_PROG || req_op == OP_ERASE))
      |=> op_refused_q && mst_q == M_IDLE) else $error("protected op issued"); // RULE7
   chk_cs_busy: assert property (@(posedge clk) disable iff (!resetn)
      (mst_q == M_BUSY) |-> !chip_sel_n_q || $past(mst_q) != M_BUSY)
      else $error("chip select dropped in busy"); // RULE5
   chk_addr_count: assert property (@(posedge clk) disable iff (!resetn)
      (mst_q == M_ADDR) |-> acnt_q < 3'(ADDR_CYCLES)) else $error("address overrun"); // RULE20
   chk_busy_wait: assert property (@(posedge clk) disable iff (!resetn)
      (mst_q == M_BUSY && $past(mst_q) != M_BUSY) |-> ##[1:4] mst_q == M_BUSY)
      else $error("busy wait skipped"); // RULE19
endmodule

// ===== nfh_pkg.sv
// Package for the NAND flash host controller: command codes, pin timing
// counts and operation types. Assumes a 25 MHz system clock.
package nfh_pkg;
   localparam int  CLK_PERIOD_NS      = 40;
   // Pin phase lengths in clock cycles (each at least one 40 ns cycle)
   localparam int  SETUP_NS           = 12;
   localparam int  SETUP_CYC          = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int  PULSE_NS           = 12;
   localparam int  PULSE_CYC          = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int  WE_TO_BUSY_NS      = 100;
   localparam int  WE_TO_BUSY_CYC     = (WE_TO_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int  WE_TO_RE_NS        = 60;
   localparam int  WE_TO_RE_CYC       = (WE_TO_RE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int  HOLD_NS            = 25;
   localparam int  HOLD_CYC           = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Longest busy waits, used as watchdog limits
   localparam int  PROG_TIME_US       = 700;
   localparam int  PROG_TIME_CYC      = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int  ERASE_TIME_US      = 5000;
   localparam int  ERASE_TIME_CYC     = ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int  ADDR_CYCLES        = 5;
   localparam int  ECC_SECTORS        = 4;
   localparam int  MAX_PARTIAL_PROG   = 4;
   // Command codes
   localparam logic [7:0] CMD_READ_1    = 8'h00;
   localparam logic [7:0] CMD_READ_2    = 8'h30;
   localparam logic [7:0] CMD_PROG_1    = 8'h80;
   localparam logic [7:0] CMD_PROG_2    = 8'h10;
   localparam logic [7:0] CMD_MPROG_2   = 8'h11;
   localparam logic [7:0] CMD_ERASE_1   = 8'h60;
   localparam logic [7:0] CMD_ERASE_2   = 8'hd0;
   localparam logic [7:0] CMD_ID        = 8'h90;
   localparam logic [7:0] CMD_STATUS    = 8'h70;
   localparam logic [7:0] CMD_ECC_STAT  = 8'h7a;
   localparam logic [7:0] CMD_RESET     = 8'hff;
   // Operation requested by the user side
   typedef enum logic [2:0] {
      OP_READ   = 3'h0,
      OP_PROG   = 3'h1,
      OP_ERASE  = 3'h2,
      OP_ID     = 3'h3,
      OP_STATUS = 3'h4,
      OP_ECC    = 3'h5,
      OP_RESET  = 3'h6
   } nfh_op_type;
   // Pin cycle kinds driven by the cycle engine
   typedef enum logic [1:0] {
      CYC_CMD  = 2'h0,
      CYC_ADDR = 2'h1,
      CYC_DIN  = 2'h2,
      CYC_DOUT = 2'h3
   } nfh_cyc_type;
endpackage

// ===== nfh_cycle.sv
// Single pin cycle engine: one command, address, data-in or data-out cycle
// on the shared byte port. Assumes inputs from the main sequencer, same clock.
`timescale 1ns/1ns
module nfh_cycle
   import nfh_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // Request
   input  wire logic        start,
   input  wire nfh_cyc_type kind,
   input  wire logic [7:0]  wdata,
   output logic             done,
   output logic [7:0]       rdata_q,
   // Port data input already synchronised
   input  wire logic [7:0]  port_in,
   // Flash strobes and shared port drive
   output logic             cmd_latch_q,
   output logic             addr_latch_q,
   output logic             write_strobe_n_q,
   output logic             read_strobe_n_q,
   output logic [7:0]       port_out_q,
   output logic             port_oe_q
);
   typedef enum logic [3:0] {
      S_IDLE  = 4'b0001,
      S_SETUP = 4'b0010,
      S_PULSE = 4'b0100,
      S_HOLD  = 4'b1000
   } nfh_cst_type;
   nfh_cst_type cst_q;
   logic [2:0]  cnt_q;
   nfh_cyc_type kind_q;
   // Sample taken at the end of a low phase two cycles longer than a write pulse, to cover port synchroniser delay
   localparam int SAMPLE_CYC = PULSE_CYC + 2;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cst_q            <= S_IDLE;
         cnt_q            <= 3'h0;
         kind_q           <= CYC_CMD;
         cmd_latch_q      <= 1'b0;
         addr_latch_q     <= 1'b0;
         write_strobe_n_q <= 1'b1;
         read_strobe_n_q  <= 1'b1;
         port_out_q       <= 8'h00;
         port_oe_q        <= 1'b0;
         rdata_q          <= 8'h00;
      end else begin
         case (cst_q)
            S_IDLE: begin
               if (start) begin
                  kind_q       <= kind;
                  cmd_latch_q  <= (kind == CYC_CMD);  // RULE1
                  addr_latch_q <= (kind == CYC_ADDR); // RULE2
                  // Never drive while the flash may still be driving
                  port_oe_q    <= (kind != CYC_DOUT); // RULE18
                  port_out_q   <= wdata;              // RULE3
                  cnt_q        <= 3'(SETUP_CYC);
                  cst_q        <= S_SETUP;
               end
            end
            S_SETUP: begin
               if (cnt_q <= 3'h1) begin
                  if (kind_q == CYC_DOUT) begin
                     read_strobe_n_q  <= 1'b0;          // RULE6
                     cnt_q            <= 3'(SAMPLE_CYC);
                  end else begin
                     write_strobe_n_q <= 1'b0;
                     cnt_q            <= 3'(PULSE_CYC);
                  end
                  cst_q <= S_PULSE;
               end else begin
                  cnt_q <= cnt_q - 3'h1;
               end
            end
            S_PULSE: begin
               if (cnt_q <= 3'h1) begin
                  if (kind_q == CYC_DOUT) begin
                     rdata_q <= port_in;
                  end
                  // Rising write strobe latches command, address or data
                  write_strobe_n_q <= 1'b1;             // RULE1 RULE2
                  read_strobe_n_q  <= 1'b1;             // RULE9
                  cnt_q            <= 3'(HOLD_CYC);
                  cst_q            <= S_HOLD;
               end else begin
                  cnt_q <= cnt_q - 3'h1;
               end
            end
            S_HOLD: begin
               if (cnt_q <= 3'h1) begin
                  cmd_latch_q  <= 1'b0;
                  addr_latch_q <= 1'b0;
                  port_oe_q    <= 1'b0;
                  cst_q        <= S_IDLE;
               end else begin
                  cnt_q <= cnt_q - 3'h1;
               end
            end
            default: cst_q <= S_IDLE;
         endcase
      end
   end

   assign done = (cst_q == S_HOLD) && (cnt_q <= 3'h1);

   chk_strobe_excl: assert property (@(posedge clk) disable iff (!resetn)
      !(!write_strobe_n_q && !read_strobe_n_q)) else $error("both strobes low"); // RULE3
   chk_drive_read: assert property (@(posedge clk) disable iff (!resetn)
      !read_strobe_n_q |-> !port_oe_q) else $error("host drives during read"); // RULE18
   chk_latch_excl: assert property (@(posedge clk) disable iff (!resetn)
      !write_strobe_n_q |-> !(cmd_latch_q && addr_latch_q)) else $error("both latches"); // RULE1
   chk_addr_stable: assert property (@(posedge clk) disable iff (!resetn)
      (!write_strobe_n_q && addr_latch_q) |=> write_strobe_n_q && addr_latch_q
      && $stable(port_out_q)) else $error("address not held at rise"); // RULE2
endmodule

// ===== nfh_flash_model.sv
// Behavioural flash device that answers the host controller's pins.
// Assumes one host on the shared port; the model reacts to pin edges only.
`timescale 1ns/1ns
module nfh_flash_model #(
   parameter int         BUSY_NS = 2000,
   parameter logic [7:0] ID_BYTE = 8'h5c  // Arbitrary value
)
(
   // Host pins
   input  wire logic       chip_sel_n,
   input  wire logic       cmd_latch,
   input  wire logic       addr_latch,
   input  wire logic       write_strobe_n,
   input  wire logic       read_strobe_n,
   input  wire logic       write_protect_n,
   input  wire logic [7:0] host_out,
   input  wire logic       host_oe,
   // Device outputs
   output logic            ready_busy_out,
   output logic [7:0]      port_bus
);
   logic [7:0]  cmd_log[$];
   logic [7:0]  addr_log[$];
   logic [7:0]  page[0:255];
   logic [7:0]  dev_q = 8'h00;
   logic        dev_oe = 1'b0;
   logic [11:0] col = 12'h000;
   logic [1:0]  mode = 2'h0;
   int          n = 0;
   int          clash = 0;
   event        go_busy;
   wire         standby = chip_sel_n & ready_busy_out;
   // A released port shows the inverse of the last byte, never a stale copy
   assign port_bus = host_oe ? host_out : dev_oe ? dev_q : ~dev_q;
   initial begin
      ready_busy_out = 1'b1;
      for (int i = 0; i < 256; i++) page[i] = i[7:0] ^ 8'h3c;
   end
   always @(go_busy) begin
      ready_busy_out = 1'b0;
      #(BUSY_NS);
      ready_busy_out = 1'b1;
   end
   always @(posedge write_strobe_n) begin
      if (!chip_sel_n && cmd_latch) begin
         cmd_log.push_back(port_bus);
         n = 0;
         if (port_bus == 8'h70) mode = 2'h1;
         if (port_bus == 8'h7a) mode = 2'h2;
         if (port_bus == 8'h90) mode = 2'h3;
         if (port_bus == 8'h70 || port_bus == 8'h7a) col = 12'h000;
         if (port_bus == 8'h30) mode = 2'h0;
         if (port_bus == 8'h30 || port_bus == 8'hff) ->go_busy;
         if (port_bus == 8'h11) ready_busy_out = 1'b1;
         if ((port_bus == 8'h10 || port_bus == 8'hd0) && write_protect_n) ->go_busy;
         if (port_bus == 8'hd0 && write_protect_n) begin
            for (int i = 0; i < 256; i++) page[i] = 8'hff;
         end
      end else if (!chip_sel_n && addr_latch) begin
         addr_log.push_back(port_bus);
         if (n == 0) col[7:0] = port_bus;
         if (n == 1) col[11:8] = port_bus[3:0];
         n++;
      end else if (!chip_sel_n && write_protect_n && cmd_log.size() > 0) begin
         page[col[7:0]] = port_bus;
         col = col + 12'h001;
      end
   end
   always @(negedge read_strobe_n) begin
      if (!chip_sel_n) begin
         case (mode)
            2'h0: dev_q = page[col[7:0]];
            2'h1: dev_q = {write_protect_n, ready_busy_out, 6'h00};
            2'h2: dev_q = {6'h00, col[1:0]};
            default: dev_q = ID_BYTE ^ col[7:0];
         endcase
         dev_oe = 1'b1;
         col = col + 12'h001;
      end
   end
   always @(posedge read_strobe_n) dev_oe <= #25 1'b0;
   always @(negedge write_strobe_n or posedge chip_sel_n) dev_oe = 1'b0;
   always @(posedge host_oe) if (dev_oe) clash++;
endmodule

// ===== nfh_ctrl_bench.sv
// Self-checking bench for the flash host controller with a device model.
// Assumes a 25 MHz clock and shortened busy timeouts.
`timescale 1ns/1ns
module nfh_ctrl_bench;
   import nfh_pkg::*;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        req_valid = 1'b0;
   logic        req_ready;
   nfh_op_type  req_op = OP_READ;
   logic [11:0] req_col = 12'h000;
   logic [16:0] req_row = 17'h00000;
   logic [11:0] req_len = 12'h000;
   logic        req_wp_n = 1'b0;
   logic [7:0]  wbuf[0:7];
   logic [7:0]  rbuf[0:7];
   int          wi = 0;
   int          rn = 0;
   logic        wr_take, rd_valid_q, op_done_q, op_timeout_q, op_refused_q, refused;
   logic [7:0]  rd_data_q, port_bus, port_out;
   logic        chip_sel_n_q, cmd_latch, addr_latch, write_strobe_n, read_strobe_n;
   logic        write_protect_n_q, ready_busy_out, port_oe;
   int          mismatches = 0;
   int          num_checks = 0;
   wire  [7:0]  wr_data = wbuf[wi[2:0]];
   always #20 clk = ~clk;
   nfh_ctrl #(.PROG_TIMEOUT(200), .ERASE_TIMEOUT(200)) dut_u (
      .clk(clk), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
      .req_op(req_op), .req_col(req_col), .req_row(req_row), .req_len(req_len),
      .req_wp_n(req_wp_n), .wr_data(wr_data), .wr_take(wr_take), .rd_data_q(rd_data_q),
      .rd_valid_q(rd_valid_q), .op_done_q(op_done_q), .op_timeout_q(op_timeout_q),
      .op_refused_q(op_refused_q), .chip_sel_n_q(chip_sel_n_q), .cmd_latch(cmd_latch),
      .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
      .read_strobe_n(read_strobe_n), .write_protect_n_q(write_protect_n_q),
      .ready_busy_out(ready_busy_out), .shared_byte_port_in(port_bus),
      .shared_byte_port_out(port_out), .shared_byte_port_oe(port_oe));
   nfh_flash_model flash_u (
      .chip_sel_n(chip_sel_n_q), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
      .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
      .write_protect_n(write_protect_n_q), .host_out(port_out), .host_oe(port_oe),
      .ready_busy_out(ready_busy_out), .port_bus(port_bus));
   always @(posedge clk) begin
      if (wr_take === 1'b1) wi <= wi + 1;
      if (rd_valid_q === 1'b1 && rn < 8) rbuf[rn] <= rd_data_q;
      if (rd_valid_q === 1'b1) rn <= rn + 1;
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic run_op(input nfh_op_type op, input logic [11:0] c, input logic [16:0] r,
                         input logic [11:0] len, input logic wp);
      int t;
      flash_u.cmd_log.delete();
      flash_u.addr_log.delete();
      refused = 1'b0;
      while (ready_busy_out !== 1'b1) @(posedge clk);
      repeat (2) @(posedge clk);
      @(posedge clk);
      req_op <= op;
      req_col <= c;
      req_row <= r;
      req_len <= len;
      req_wp_n <= wp;
      req_valid <= 1'b1;
      wi <= 0;
      rn <= 0;
      t = 0;
      do @(negedge clk); while (req_ready !== 1'b1 && ++t < 2000);
      @(posedge clk) req_valid <= 1'b0;
      t = 0;
      do begin
         @(negedge clk);
         if (op_refused_q === 1'b1) refused = 1'b1;
      end while (op_done_q !== 1'b1 && !refused && ++t < 2000);
      chk1(t < 2000, 1'b1);
      repeat (8) @(posedge clk);
   endtask
   task automatic cmds(input logic [7:0] a, input logic [7:0] b, input int k);
      chk8(8'(flash_u.cmd_log.size()), 8'(k));
      chk8(flash_u.cmd_log[0], a);
      if (k > 1) chk8(flash_u.cmd_log[1], b);
   endtask
   task automatic t_reset;
      chk1(chip_sel_n_q, 1'b1);
      chk1(write_strobe_n, 1'b1);
      chk1(read_strobe_n, 1'b1);
      chk1(cmd_latch, 1'b0);
      chk1(port_oe, 1'b0);
      chk1(write_protect_n_q, 1'b0);
   endtask
   task automatic t_prog_read;
      logic [7:0] ad[5] = '{8'h23, 8'h01, 8'hcd, 8'hab, 8'h01};
      wbuf = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88};
      run_op(OP_PROG, 12'h123, 17'h1abcd, 12'h004, 1'b1);
      cmds(8'h80, 8'h10, 2);
      for (int i = 0; i < 5; i++) chk8(flash_u.addr_log[i], ad[i]);
      for (int i = 0; i < 4; i++) chk8(flash_u.page[8'h23 + i], wbuf[i]);
      chk1(op_timeout_q, 1'b0);
      run_op(OP_READ, 12'h123, 17'h1abcd, 12'h004, 1'b1);
      cmds(8'h00, 8'h30, 2);
      for (int i = 0; i < 5; i++) chk8(flash_u.addr_log[i], ad[i]);
      for (int i = 0; i < 4; i++) chk8(rbuf[i], wbuf[i]);
      chk8(8'(rn), 8'h04);
      chk1(op_timeout_q, 1'b0);
   endtask
   task automatic t_refuse_erase;
      run_op(OP_PROG, 12'h000, 17'h00001, 12'h002, 1'b0);
      chk1(refused, 1'b1);
      chk8(8'(flash_u.cmd_log.size()), 8'h00);
      run_op(OP_ERASE, 12'h000, 17'h1abcd, 12'h000, 1'b0);
      chk1(refused, 1'b1);
      run_op(OP_ERASE, 12'h000, 17'h1abcd, 12'h000, 1'b1);
      cmds(8'h60, 8'hd0, 2);
      chk8(8'(flash_u.addr_log.size()), 8'h03);
      chk8(flash_u.addr_log[2], 8'h01);
      chk8(flash_u.page[8'h23], 8'hff);
      for (int i = 0; i < 5; i++) begin
         run_op(OP_PROG, 12'h000, 17'h00002, 12'h001, 1'b1);
         chk1(refused, i == 4);
      end
   endtask
   task automatic t_queries;
      run_op(OP_STATUS, 12'h000, 17'h00000, 12'h001, 1'b1);
      cmds(8'h70, 8'h00, 1);
      chk8(rbuf[0], 8'hc0);
      run_op(OP_ECC, 12'h000, 17'h00000, 12'h001, 1'b1);
      cmds(8'h7a, 8'h00, 1);
      for (int i = 0; i < 4; i++) chk8(rbuf[i], 8'(i));
      chk8(8'(rn), 8'h04);
      run_op(OP_ID, 12'h000, 17'h00000, 12'h002, 1'b1);
      cmds(8'h90, 8'h00, 1);
      chk8(rbuf[1], flash_u.ID_BYTE ^ 8'h01);
      run_op(OP_RESET, 12'h000, 17'h00000, 12'h000, 1'b1);
      cmds(8'hff, 8'h00, 1);
      chk1(chip_sel_n_q, 1'b1);
      chk8(8'(flash_u.clash), 8'h00);
   endtask
   task automatic finish_test;
      $display("mismatches %0d num_checks %0d", mismatches, num_checks);
      if (mismatches == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      @(negedge clk);
      t_reset();
      t_prog_read();
      t_refuse_erase();
      t_queries();
      finish_test();
   end
   initial begin
      #(40 * 40000);
      mismatches++;
      finish_test();
   end
endmodule
